/* File: picr_defines.svh */
`ifndef PICR_DEFINES_SVH
`define PICR_DEFINES_SVH
// ********************************************************************
// register offsets
// ********************************************************************
`define PICR_OFS_INT_MASK      8'h01
`define PICR_OFS_PIN_CFG       8'h02
`define PICR_OFS_QUEUE_THRESH  8'h06
`define PICR_OFS_REV_ID        8'h08
`define PICR_OFS_TARGET_ADDR   8'h09
`define PICR_OFS_OSC_RATIO     8'h0A
`define PICR_OFS_PIN2_FUNC     8'h0B
`define PICR_OFS_CAL_CTRL      8'h50
// ********************************************************************
// field positions and values
// ********************************************************************
`define PICR_BIT_QUEUE_MASK    8
`define PICR_BIT_PIN2_DRV      9
`define PICR_BIT_PIN2_POL      8
`define PICR_BIT_PIN1_ENA      2
`define PICR_BIT_PIN1_DRV      1
`define PICR_BIT_PIN1_POL      0
`define PICR_BIT_CAL_EN        5
`define PICR_ADDR_KEY          8'hAD
`define PICR_RST_INT_MASK      16'h01FF
`define PICR_RST_TARGET_ADDR   7'h64
`define PICR_FUNC_INTERRUPT    5'h01
`define PICR_FUNC_SLOT_SPAN    5'h02
`define PICR_FUNC_LOW          5'h10
`define PICR_FUNC_HIGH         5'h11
`define PICR_SLOW_PERIODS      2'h2
`endif

/* File: picr_pkg.sv */
package picr_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_WAIT = 2'h1,
    CAL_RUN  = 2'h3
  } picr_cal_t;

  typedef struct packed {
    logic [15:0] int_mask;
    logic [15:0] pin_cfg;
    logic [5:0]  queue_thresh;
    logic [6:0]  target_addr;
    logic [11:0] osc_ratio;
    logic [4:0]  pin2_func;
    logic        cal_en;
    picr_cal_t   cal_state;
    logic [1:0]  slow_edges;
    logic [11:0] fast_count;
    logic [2:0]  slow_sync;
    logic [2:0]  fast_sync;
    logic [15:0] rdata;
    logic        pin1_out;
    logic        pin1_oe;
    logic        pin2_out;
    logic        pin2_oe;
    logic        queue_int;
  } picr_state_t;
endpackage : picr_pkg

/* File: picr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "picr_defines.svh"
module picr_regs #(
  parameter int           QUEUE_W  = 7,
  parameter logic [7:0]   REVISION = 8'h01, // arbitrary value
  parameter logic [7:0]   PART_ID  = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RESET_N,
  // register port
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [15:0]        REG_WDATA,
  output var  logic [15:0]        REG_RDATA,
  // datapath status
  input  wire logic [QUEUE_W-1:0] QUEUE_WORDS,
  input  wire logic               OTHER_INT,
  input  wire logic               SLOT_SPAN,
  // oscillators, asynchronous
  input  wire logic               SLOW_OSC,
  input  wire logic               FAST_OSC,
  // status outputs
  output var  logic               QUEUE_INT,
  output var  logic [6:0]         TARGET_ADDR,
  // pins
  output var  logic               FIRST_OUTPUT_PIN_O,
  output var  logic               FIRST_OUTPUT_PIN_OE,
  output var  logic               SECOND_OUTPUT_PIN_O,
  output var  logic               SECOND_OUTPUT_PIN_OE
);
  // ********************************************************************
  // state
  // ********************************************************************
  picr_pkg::picr_state_t q, d;
  logic       queue_over;
  logic       int_any;
  logic       act1;
  logic       act2;
  logic       slow_rise;
  logic       fast_rise;
  logic [5:0] wsel;

  // ********************************************************************
  // decoders
  // ********************************************************************
  function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                           input logic drv, input logic ena);
    logic [1:0] r;
    r = 2'h0;
    r[1] = act ^ pol;
    if (!ena) r[0] = 1'b0;
    else if (drv) r[0] = act;
    else r[0] = 1'b1;
    return r;
  endfunction : pin_drive

  // second pin: codes outside the handled set read as the interrupt function
  function automatic logic pin2_activity(input logic [4:0] code, input logic intr,
                                         input logic span);
    logic a;
    a = intr;
    unique case (code)
      `PICR_FUNC_SLOT_SPAN: a = span;
      `PICR_FUNC_LOW:       a = 1'b0;
      `PICR_FUNC_HIGH:      a = 1'b1;
      default:              a = intr;
    endcase
    return a;
  endfunction : pin2_activity

  // one-hot write select, shared by the field updates and the run abort
  function automatic logic [5:0] write_select(input logic wr, input logic [7:0] addr);
    logic [5:0] s;
    s = 6'h00;
    if (wr) begin
      unique case (addr)
        `PICR_OFS_INT_MASK:     s[0] = 1'b1;
        `PICR_OFS_PIN_CFG:      s[1] = 1'b1;
        `PICR_OFS_QUEUE_THRESH: s[2] = 1'b1;
        `PICR_OFS_TARGET_ADDR:  s[3] = 1'b1;
        `PICR_OFS_PIN2_FUNC:    s[4] = 1'b1;
        `PICR_OFS_CAL_CTRL:     s[5] = 1'b1;
        default: ;
      endcase
    end
    return s;
  endfunction : write_select

  // rising edge between the second and third sync stages
  function automatic logic sync_rise(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction : sync_rise

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    d = q;
    // raw level; the mask only gates what reaches the pins
    queue_over  = 32'(QUEUE_WORDS) > 32'(q.queue_thresh);
    d.queue_int = queue_over;
    int_any     = (queue_over & ~q.int_mask[`PICR_BIT_QUEUE_MASK]) | OTHER_INT;
    slow_rise   = sync_rise(q.slow_sync);
    fast_rise   = sync_rise(q.fast_sync);
    d.slow_sync = {q.slow_sync[1:0], SLOW_OSC};
    d.fast_sync = {q.fast_sync[1:0], FAST_OSC};

    // ******************************************************************
    // register writes
    // ******************************************************************
    wsel = write_select(REG_WR, REG_ADDR);
    if (wsel[0]) d.int_mask = REG_WDATA;
    if (wsel[1]) d.pin_cfg = REG_WDATA;
    if (wsel[2]) d.queue_thresh = REG_WDATA[13:8];
    // key-protected; a wrong key leaves the address alone
    if (wsel[3] && REG_WDATA[15:8] == `PICR_ADDR_KEY) d.target_addr = REG_WDATA[7:1];
    if (wsel[4]) d.pin2_func = REG_WDATA[12:8];
    if (wsel[5]) d.cal_en = REG_WDATA[`PICR_BIT_CAL_EN];

    // ******************************************************************
    // ratio measurement
    // ******************************************************************
    // oscillators sampled in the core clock; fast osc must stay well below clock/2
    unique case (q.cal_state)
      picr_pkg::CAL_IDLE: if (q.cal_en) d.cal_state = picr_pkg::CAL_WAIT;
      picr_pkg::CAL_WAIT: begin
        if (slow_rise) begin
          d.cal_state  = picr_pkg::CAL_RUN;
          d.slow_edges = 2'h0;
          d.fast_count = 12'h000;
        end
      end
      picr_pkg::CAL_RUN: begin
        if (fast_rise) d.fast_count = q.fast_count + 12'h001;
        if (slow_rise) begin
          d.slow_edges = q.slow_edges + 2'h1;
          if (q.slow_edges + 2'h1 == `PICR_SLOW_PERIODS) begin
            d.osc_ratio = q.fast_count + {11'h000, fast_rise};
            d.cal_state = picr_pkg::CAL_IDLE;
          end
        end
      end
      default: d.cal_state = picr_pkg::CAL_IDLE;
    endcase
    // a run cut short keeps the previous result
    if (!q.cal_en && q.cal_state != picr_pkg::CAL_IDLE) d.cal_state = picr_pkg::CAL_IDLE;
    if (wsel[5] && !REG_WDATA[`PICR_BIT_CAL_EN]) d.cal_state = picr_pkg::CAL_IDLE;

    // ******************************************************************
    // read back
    // ******************************************************************
    if (REG_RD) begin
      unique case (REG_ADDR)
        `PICR_OFS_INT_MASK:     d.rdata = q.int_mask;
        `PICR_OFS_PIN_CFG:      d.rdata = q.pin_cfg;
        `PICR_OFS_QUEUE_THRESH: d.rdata = {2'h0, q.queue_thresh, 8'h00};
        `PICR_OFS_REV_ID:       d.rdata = {REVISION, PART_ID};
        `PICR_OFS_TARGET_ADDR:  d.rdata = {8'h00, q.target_addr, 1'b0};
        `PICR_OFS_OSC_RATIO:    d.rdata = {4'h0, q.osc_ratio};
        `PICR_OFS_PIN2_FUNC:    d.rdata = {3'h0, q.pin2_func, 8'h00};
        `PICR_OFS_CAL_CTRL:     d.rdata = {10'h000, q.cal_en, 5'h00};
        default:                d.rdata = 16'h0000;
      endcase
    end

    // ******************************************************************
    // pin outputs
    // ******************************************************************
    act1 = int_any;
    {d.pin1_out, d.pin1_oe} = pin_drive(act1, q.pin_cfg[`PICR_BIT_PIN1_POL],
                                        q.pin_cfg[`PICR_BIT_PIN1_DRV],
                                        q.pin_cfg[`PICR_BIT_PIN1_ENA]);
    act2 = pin2_activity(q.pin2_func, int_any, SLOT_SPAN);
    {d.pin2_out, d.pin2_oe} = pin_drive(act2, q.pin_cfg[`PICR_BIT_PIN2_POL],
                                        q.pin_cfg[`PICR_BIT_PIN2_DRV], 1'b1);
    // a floating pin shows 0, never a stale level
    d.pin1_out = d.pin1_out & d.pin1_oe;
    d.pin2_out = d.pin2_out & d.pin2_oe;
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      q              <= '0;
      q.int_mask     <= `PICR_RST_INT_MASK;
      q.target_addr  <= `PICR_RST_TARGET_ADDR;
      q.cal_state    <= picr_pkg::CAL_IDLE;
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign REG_RDATA            = q.rdata;
  assign QUEUE_INT            = q.queue_int;
  assign TARGET_ADDR          = q.target_addr;
  assign FIRST_OUTPUT_PIN_O   = q.pin1_out;
  assign FIRST_OUTPUT_PIN_OE  = q.pin1_oe;
  assign SECOND_OUTPUT_PIN_O  = q.pin2_out;
  assign SECOND_OUTPUT_PIN_OE = q.pin2_oe;
endmodule : picr_regs
`default_nettype wire

/* File: picr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module picr_host (
  // register strobes toward the block
  input  wire logic        clk,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [7:0]  addr,
  output var  logic [15:0] wdata
);
  initial {wr, rd, addr, wdata} = 26'h0000000;
  // no handshake: each strobe lasts one edge, so back to back is legal
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  task automatic get(input logic [7:0] a);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : get
endmodule : picr_host
`default_nettype wire

/* File: picr_regs_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module picr_regs_properties #(parameter int QUEUE_W = 7) (
  // bus
  input wire logic               CLOCK,
  input wire logic               RESET_N,
  input wire logic               REG_WR,
  input wire logic [7:0]         REG_ADDR,
  input wire logic [15:0]        REG_WDATA,
  // status and pins
  input wire logic [QUEUE_W-1:0] QUEUE_WORDS,
  input wire logic               OTHER_INT,
  input wire logic               SLOT_SPAN,
  input wire logic               QUEUE_INT,
  input wire logic               FIRST_OUTPUT_PIN_O,
  input wire logic               FIRST_OUTPUT_PIN_OE,
  input wire logic               SECOND_OUTPUT_PIN_O
);
  // mirrors of config, written on the same edge as the block's own
  logic [15:0] pc_q;
  logic [5:0]  th_q;
  logic        mk_q;
  logic [4:0]  fn_q;
  logic        act;
  logic [22:0] st;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      {pc_q, th_q, mk_q, fn_q} <= {16'h0000, 6'h00, 1'b1, 5'h00};
    end else if (REG_WR) begin
      if (REG_ADDR == 8'h01) mk_q <= REG_WDATA[8];
      if (REG_ADDR == 8'h02) pc_q <= REG_WDATA;
      if (REG_ADDR == 8'h06) th_q <= REG_WDATA[13:8];
      if (REG_ADDR == 8'h0B) fn_q <= REG_WDATA[12:8];
    end
  end
  assign act = (QUEUE_INT & ~mk_q) | OTHER_INT;
  assign st = {act, pc_q, fn_q, SLOT_SPAN};
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // pins lag config by one edge, so judge only after three quiet ones
  sequence s3;
    $stable(st)[*3];
  endsequence
  a_queue_raise: assert property ((QUEUE_WORDS > QUEUE_W'(th_q))[*2] |=> QUEUE_INT)
    else $error("queue interrupt missing");
  a_queue_drop: assert property ((QUEUE_WORDS <= QUEUE_W'(th_q))[*2] |=> !QUEUE_INT)
    else $error("queue interrupt stuck");
  a_pin1_shared: assert property (s3 ##0 pc_q[2:1] == 2'b11 |-> FIRST_OUTPUT_PIN_OE == act)
    else $error("open drain enable wrong");
  a_pin1_level: assert property (s3 ##0 FIRST_OUTPUT_PIN_OE |->
    FIRST_OUTPUT_PIN_O == (act ^ pc_q[0]))
    else $error("first pin level wrong");
  a_pin1_float: assert property (s3 ##0 !pc_q[2] |-> !FIRST_OUTPUT_PIN_OE)
    else $error("disabled pin driven");
  a_pin1_driven: assert property (s3 ##0 pc_q[2:1] == 2'b10 |-> FIRST_OUTPUT_PIN_OE)
    else $error("push pull pin floating");
  a_pin2_intr: assert property (s3 ##0 fn_q == 5'h01 |->
    SECOND_OUTPUT_PIN_O == ((act ^ pc_q[8]) & (act | ~pc_q[9])))
    else $error("second pin interrupt wrong");
  a_pin2_span: assert property (s3 ##0 fn_q == 5'h02 |->
    SECOND_OUTPUT_PIN_O == ((SLOT_SPAN ^ pc_q[8]) & (SLOT_SPAN | ~pc_q[9])))
    else $error("second pin span wrong");
endmodule : picr_regs_properties
bind picr_regs picr_regs_properties #(.QUEUE_W(QUEUE_W)) u_props (.*);
`default_nettype wire

/* File: pin_interrupt_config_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_interrupt_config_regs_tb;
  logic        CLOCK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        REG_WR, REG_RD, QUEUE_INT, FIRST_OUTPUT_PIN_O, FIRST_OUTPUT_PIN_OE;
  logic        OTHER_INT = 1'b0, SLOT_SPAN = 1'b0, SLOW_OSC = 1'b0, FAST_OSC = 1'b0;
  logic        SECOND_OUTPUT_PIN_O, SECOND_OUTPUT_PIN_OE;
  logic [7:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic [6:0]  QUEUE_WORDS = 7'h00, TARGET_ADDR;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  picr_regs u_dut (.*);
  picr_host u_host (.clk(CLOCK), .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR), .wdata(REG_WDATA));
  initial forever #10 CLOCK = ~CLOCK;
  // oscillators stepped from the core clock: fast 120 ns, slow 2000 ns
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    FAST_OSC <= (cyc % 6) < 3;
    SLOW_OSC <= (cyc % 100) < 50;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : tick
  task automatic t_regs;
    u_host.get(8'h08);
    chk("id", 16'h015A, REG_RDATA);
    u_host.put(8'h0A, 16'hFFFF);
    u_host.get(8'h0A);
    chk("ratio", 16'h0000, REG_RDATA);
    u_host.get(8'h30);
    chk("unmapped", 16'h0000, REG_RDATA);
    u_host.put(8'h09, 16'h0042);
    tick(1);
    chk("addr", 16'h0064, TARGET_ADDR);
    u_host.put(8'h09, 16'hAD42);
    tick(1);
    chk("addr", 16'h0021, TARGET_ADDR);
  endtask : t_regs
  task automatic t_queue;
    u_host.put(8'h06, 16'h0500);
    @(posedge CLOCK) QUEUE_WORDS <= 7'h06;
    tick(4);
    chk("qint", 1'b1, QUEUE_INT);
    chk("pin2", 1'b0, SECOND_OUTPUT_PIN_O);
    u_host.put(8'h01, 16'h00FF);
    tick(3);
    chk("pin2", 1'b1, SECOND_OUTPUT_PIN_O);
    @(posedge CLOCK) QUEUE_WORDS <= 7'h05;
    tick(4);
    chk("qint", 1'b0, QUEUE_INT);
  endtask : t_queue
  task automatic t_pins;
    logic [3:0] i;
    logic       oe;
    for (int k = 0; k < 16; k++) begin
      i = 4'(k);
      @(posedge CLOCK) OTHER_INT <= i[3];
      u_host.put(8'h02, {13'h0000, i[2:0]});
      tick(3);
      oe = i[2] & (~i[1] | i[3]);
      chk("pin1 oe", oe, FIRST_OUTPUT_PIN_OE);
      chk("pin1", oe & (i[3] ^ i[0]), FIRST_OUTPUT_PIN_O);
    end
  endtask : t_pins
  task automatic t_pin2;
    logic [4:0] fc [4] = '{5'h01, 5'h02, 5'h10, 5'h11};
    logic       a;
    for (int m = 0; m < 4; m++) begin
      // m[0] picks interrupt or span as the active source, m[1] open drain active low
      @(posedge CLOCK) {OTHER_INT, SLOT_SPAN} <= m[0] ? 2'b10 : 2'b01;
      u_host.put(8'h02, m[1] ? 16'h0300 : 16'h0000);
      foreach (fc[k]) begin
        u_host.put(8'h0B, {3'h0, fc[k], 8'h00});
        tick(3);
        a = (fc[k] == 5'h01 && m[0]) || (fc[k] == 5'h02 && !m[0]) || fc[k] == 5'h11;
        chk("pin2 oe", !m[1] || a, SECOND_OUTPUT_PIN_OE);
        chk("pin2", !m[1] && a, SECOND_OUTPUT_PIN_O);
      end
    end
  endtask : t_pin2
  task automatic t_cal;
    // sync flops may add or lose one fast edge at either end
    u_host.put(8'h50, 16'h0020);
    tick(600);
    u_host.get(8'h0A);
    chk("ratio", 1'b1, REG_RDATA >= 16'h0020 && REG_RDATA <= 16'h0023);
  endtask : t_cal
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_regs();
    t_queue();
    t_pins();
    t_pin2();
    t_cal();
    end_of_test();
  end
endmodule : pin_interrupt_config_regs_tb
`default_nettype wire
